// File: common/mste_pkg.sv
package mste_pkg;
    // widths
    localparam int PC_W      = 12;          // program counter width
    localparam int STK_DEPTH = 8;           // stack entries
    localparam int SIDX_W    = 3;           // stack index width
    localparam int STK_W     = 16;          // {flags nibble, pc}
    localparam int REG_AW    = 8;           // register bus address width
    localparam int DW        = 32;          // register bus data width

    // timer prescale: timer mode advances once per 32 S4 ticks (160 cycles)
    localparam logic [4:0] PRE_LAST  = 5'h1F;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // opcodes
    localparam logic [7:0] OP_NOP      = 8'h00;
    localparam logic [7:0] OP_SUBEXIT  = 8'h83;
    localparam logic [7:0] OP_SUBEXITF = 8'h93;
    localparam logic [7:0] OP_TIEN     = 8'h25;
    localparam logic [7:0] OP_TIDIS    = 8'h35;
    localparam logic [7:0] OP_RDTMR    = 8'h42;
    localparam logic [7:0] OP_LDTMR    = 8'h62;
    localparam logic [7:0] OP_HALTCNT  = 8'h65;
    localparam logic [7:0] OP_EVCOUNT  = 8'h45;
    localparam logic [7:0] OP_TIMING   = 8'h55;
    localparam logic [7:0] OP_JOVF     = 8'h16;
    localparam logic [4:0] OPL_CALL    = 5'h14;  // low five bits
    localparam logic [4:0] OPL_JUMP    = 5'h04;
    localparam logic [5:0] OPH_EXPMOV  = 6'h0F;  // upper six bits
    localparam logic [1:0] EXP_CMD_WR  = 2'h1;

    // register byte addresses
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ACC   = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_PC    = 8'h0C;
    localparam logic [7:0] REG_TCNT  = 8'h10;
    localparam logic [7:0] REG_STAT  = 8'h14;
    localparam logic [7:0] REG_IEN   = 8'h18;
    localparam logic [7:0] REG_ICLR  = 8'h1C;

    // control fields
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_BANK = 1;
    localparam int CTRL_EXT  = 2;
    localparam int CTRL_TIE  = 3;
    localparam int CTRL_MODE = 4;           // two bits, read only

    // event bits
    localparam int EV_W    = 3;
    localparam int EV_TIRQ = 0;
    localparam int EV_CALL = 1;
    localparam int EV_EXIT = 2;

    typedef enum logic [4:0] {
        PH_S1 = 5'b00001,
        PH_S2 = 5'b00010,
        PH_S3 = 5'b00100,
        PH_S4 = 5'b01000,
        PH_S5 = 5'b10000
    } mste_phase_e;

    typedef enum logic [1:0] {
        TM_STOP  = 2'h0,
        TM_TIMER = 2'h1,
        TM_EVENT = 2'h2
    } mste_tmode_e;
endpackage : mste_pkg

// File: common/mste_link_if.sv
interface mste_link_if;
    import mste_pkg::*;
    logic                push;      // store return frame
    logic                pop;       // drop top frame
    logic [STK_W-1:0]    pushData;  // {flags, pc}
    logic [STK_W-1:0]    topData;   // newest frame
    logic [SIDX_W-1:0]   index;     // current stack index
    logic                tick;      // S4 time base strobe
    logic                load;      // overwrite count
    logic [7:0]          loadVal;
    logic                modeWr;    // change counting mode
    mste_tmode_e         modeSet;
    mste_tmode_e         mode;
    logic [7:0]          count;
    logic                ovf;       // one-cycle terminal count pulse
    modport core (output push, pop, pushData, tick, load, loadVal,
                  modeWr, modeSet,
                  input topData, index, mode, count, ovf);
    modport stk (input push, pop, pushData, output topData, index);
    modport tmr (input tick, load, loadVal, modeWr, modeSet,
                 output mode, count, ovf);
endinterface : mste_link_if

// File: src/mste_stack.sv
module mste_stack (
    input wire logic clk_sys,
    input wire logic rst_n,
    mste_link_if.stk lnk
);
    import mste_pkg::*;

    logic [STK_W-1:0]  mem_r   [STK_DEPTH];  // frame storage
    logic [STK_W-1:0]  mem_nxt [STK_DEPTH];
    logic [SIDX_W-1:0] idx_r;                // next free slot
    logic [SIDX_W-1:0] idx_nxt;

    // per entry write and hold
    for (genvar i = 0; i < STK_DEPTH; i++) begin : g_ent
        assign mem_nxt[i] = (lnk.push && idx_r == SIDX_W'(i)) ?
                            lnk.pushData : mem_r[i];
        always_ff @(posedge clk_sys) begin
            if (!rst_n) mem_r[i] <= '0;
            else        mem_r[i] <= mem_nxt[i];
        end
    end

    // index wraps silently: depth overrun overwrites oldest slot
    always_comb begin
        idx_nxt = idx_r;
        if (lnk.push)     idx_nxt = idx_r + SIDX_W'(1);
        else if (lnk.pop) idx_nxt = idx_r - SIDX_W'(1);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) idx_r <= '0;
        else        idx_r <= idx_nxt;
    end

    assign lnk.topData = mem_r[idx_r - SIDX_W'(1)];
    assign lnk.index   = idx_r;
endmodule : mste_stack

// File: src/mste_timer.sv
module mste_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic evtPin,
    mste_link_if.tmr lnk
);
    import mste_pkg::*;

    logic [1:0]  evtSync_r, evtSync_nxt;   // pin synchroniser
    logic        evtPrev_r, evtPrev_nxt;   // for edge detect
    logic [4:0]  pre_r, pre_nxt;           // time base prescaler
    logic [7:0]  cnt_r, cnt_nxt;
    mste_tmode_e mode_r, mode_nxt;
    logic        ovf_r, ovf_nxt;
    logic        inc;

    // counting: prescaled tick or falling event edge
    always_comb begin
        evtSync_nxt = {evtSync_r[0], evtPin};
        evtPrev_nxt = evtSync_r[1];
        pre_nxt     = pre_r;
        cnt_nxt     = cnt_r;
        mode_nxt    = mode_r;
        ovf_nxt     = 1'b0;
        inc         = 1'b0;
        if (mode_r == TM_TIMER && lnk.tick) begin
            pre_nxt = pre_r + 5'h01;
            inc     = (pre_r == PRE_LAST);
        end
        if (mode_r == TM_EVENT)
            inc = evtPrev_r & ~evtSync_r[1];
        if (inc) begin
            cnt_nxt = cnt_r + 8'h01;
            ovf_nxt = (cnt_r == COUNT_MAX);
        end
        // a load overrides a coincident increment
        if (lnk.load) cnt_nxt = lnk.loadVal;
        if (lnk.modeWr) begin
            mode_nxt = lnk.modeSet;
            pre_nxt  = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            evtSync_r <= '0;
            evtPrev_r <= 1'b0;
            pre_r     <= '0;
            cnt_r     <= '0;
            mode_r    <= TM_STOP;
            ovf_r     <= 1'b0;
        end else begin
            evtSync_r <= evtSync_nxt;
            evtPrev_r <= evtPrev_nxt;
            pre_r     <= pre_nxt;
            cnt_r     <= cnt_nxt;
            mode_r    <= mode_nxt;
            ovf_r     <= ovf_nxt;
        end
    end

    assign lnk.count = cnt_r;
    assign lnk.mode  = mode_r;
    assign lnk.ovf   = ovf_r;
endmodule : mste_timer

// File: src/mste_core.sv
// Added by the designer: the register addresses and the plain strobed port.
module mste_core (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [mste_pkg::REG_AW-1:0] regAddr,
    input  wire logic [mste_pkg::DW-1:0]   regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [mste_pkg::DW-1:0]   regRdata,
    output logic                           irq,
    input  wire logic [7:0]                progData,
    output logic      [mste_pkg::PC_W-1:0] progAddr,
    output logic                           progAddrValid,
    input  wire logic                      evtPin,
    output logic      [3:0]                expNibble,
    output logic                           expCmdStb,
    output logic                           expDataStb
);
    import mste_pkg::*;

    mste_link_if lnk ();

    mste_stack u_stack (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .lnk     (lnk)
    );

    mste_timer u_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .evtPin  (evtPin),
        .lnk     (lnk)
    );

    // sequencer state
    mste_phase_e      phase_r, phase_nxt;     // S1..S5
    logic             cyc2_r, cyc2_nxt;       // second machine cycle
    logic [7:0]       op_r, op_nxt;           // opcode
    logic [7:0]       imm_r, imm_nxt;         // second byte
    logic [PC_W-1:0]  pc_r, pc_nxt;
    // programmer state
    logic [7:0]       acc_r, acc_nxt;         // accumulator
    logic [3:0]       flagsHi_r, flagsHi_nxt; // flags word upper nibble
    logic             tovf_r, tovf_nxt;       // timer overflow flag
    logic             tie_r, tie_nxt;         // timer irq enable latch
    logic             run_r, run_nxt;         // sequencer go
    logic             bank_r, bank_nxt;       // program bank flip-flop
    logic             ext_r, ext_nxt;         // external program memory
    logic [EV_W-1:0]  stat_r, stat_nxt;       // sticky events
    logic [EV_W-1:0]  ien_r, ien_nxt;         // event enables
    // registered outputs
    logic [PC_W-1:0]  pAddr_r, pAddr_nxt;
    logic             pVal_r, pVal_nxt;
    logic [3:0]       xNib_r, xNib_nxt;
    logic             xCmd_r, xCmd_nxt;
    logic             xDat_r, xDat_nxt;
    logic [DW-1:0]    rdata_r, rdata_nxt;
    // program data synchroniser
    logic [1:0][7:0]  pSync_r, pSync_nxt;

    // decode
    logic isCall, isJump, isExit, isExitF, isJovf, isMov;
    logic twoCyc, twoByte, incPc, c1, exec2;
    logic [EV_W-1:0] ev, clr;
    logic [PC_W-1:0] callTgt;                 // call and jump target, also used by checks

    // instruction classes
    always_comb begin
        isCall  = op_r[4:0] == OPL_CALL;
        isJump  = op_r[4:0] == OPL_JUMP;
        isExit  = op_r == OP_SUBEXIT;
        isExitF = op_r == OP_SUBEXITF;
        isJovf  = op_r == OP_JOVF;
        isMov   = op_r[7:2] == OPH_EXPMOV;
        twoByte = isCall | isJump | isJovf;
        twoCyc  = twoByte | isExit | isExitF;
        c1      = ~cyc2_r;
        incPc   = c1 | twoByte;
        exec2   = cyc2_r && phase_r == PH_S3;
        callTgt = {bank_r, op_r[7:5], imm_r};
    end

    // stack and timer requests
    always_comb begin
        lnk.push     = exec2 && isCall;
        lnk.pop      = exec2 && (isExit || isExitF);
        lnk.pushData = {flagsHi_r, pc_r};
        lnk.tick     = run_r && phase_r == PH_S4;
        lnk.load     = c1 && phase_r == PH_S5 &&
                       op_r == OP_LDTMR;
        lnk.loadVal  = acc_r;
        lnk.modeWr   = 1'b0;
        lnk.modeSet  = TM_STOP;
        if (c1 && phase_r == PH_S5) begin
            unique case (op_r)
                OP_HALTCNT: begin
                    lnk.modeWr  = 1'b1;
                    lnk.modeSet = TM_STOP;
                end
                OP_EVCOUNT: begin
                    lnk.modeWr  = 1'b1;
                    lnk.modeSet = TM_EVENT;
                end
                OP_TIMING: begin
                    lnk.modeWr  = 1'b1;
                    lnk.modeSet = TM_TIMER;
                end
                default: ;
            endcase
        end
    end

    // event sources and software clear
    always_comb begin
        ev          = '0;
        ev[EV_TIRQ] = lnk.ovf & tie_r;
        ev[EV_CALL] = lnk.push;
        ev[EV_EXIT] = lnk.pop;
        clr         = (regWr && regAddr == REG_ICLR) ?
                      regWdata[EV_W-1:0] : '0;
    end

    // program data crosses from the pins
    always_comb begin
        pSync_nxt = {pSync_r[0], progData};
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) pSync_r <= '0;
        else        pSync_r <= pSync_nxt;
    end

    // execution and register writes
    always_comb begin
        phase_nxt   = phase_r;
        cyc2_nxt    = cyc2_r;
        op_nxt      = op_r;
        imm_nxt     = imm_r;
        pc_nxt      = pc_r;
        acc_nxt     = acc_r;
        flagsHi_nxt = flagsHi_r;
        tovf_nxt    = tovf_r;
        tie_nxt     = tie_r;
        run_nxt     = run_r;
        bank_nxt    = bank_r;
        ext_nxt     = ext_r;
        ien_nxt     = ien_r;
        pAddr_nxt   = pAddr_r;
        pVal_nxt    = 1'b0;
        xNib_nxt    = xNib_r;
        xCmd_nxt    = 1'b0;
        xDat_nxt    = 1'b0;
        unique case (phase_r)
            PH_S1: begin
                // idle in S1 while stopped
                if (run_r) begin
                    phase_nxt = PH_S2;
                    if (c1) op_nxt  = pSync_r[1];
                    else    imm_nxt = pSync_r[1];
                    if (incPc) begin
                        pAddr_nxt = pc_r + PC_W'(1);
                        pVal_nxt  = ext_r;
                    end
                end
            end
            PH_S2: begin
                phase_nxt = PH_S3;
                if (incPc) pc_nxt = pc_r + PC_W'(1);
                // command and port field go out in S3
                if (c1 && isMov) begin
                    xNib_nxt = {EXP_CMD_WR, op_r[1:0]};
                    xCmd_nxt = 1'b1;
                end
            end
            PH_S3: begin
                phase_nxt = PH_S4;
                if (cyc2_r) begin
                    if (isCall || isJump) begin
                        pc_nxt    = callTgt;
                        pAddr_nxt = callTgt;
                    end else if (isExit || isExitF) begin
                        pc_nxt    = lnk.topData[PC_W-1:0];
                        pAddr_nxt = lnk.topData[PC_W-1:0];
                        if (isExitF)
                            flagsHi_nxt = lnk.topData[STK_W-1:PC_W];
                    end else if (isJovf && tovf_r) begin
                        pc_nxt    = {pc_r[PC_W-1:8], imm_r};
                        pAddr_nxt = {pc_r[PC_W-1:8], imm_r};
                        tovf_nxt  = 1'b0;
                    end
                end
            end
            PH_S4: begin
                phase_nxt = PH_S5;
                if (c1 && op_r == OP_TIEN)  tie_nxt = 1'b1;
                if (c1 && op_r == OP_TIDIS) tie_nxt = 1'b0;
                // data nibble goes out in S5
                if (c1 && isMov) begin
                    xNib_nxt = acc_r[3:0];
                    xDat_nxt = 1'b1;
                end
            end
            PH_S5: begin
                phase_nxt = PH_S1;
                cyc2_nxt  = c1 & twoCyc;
                if (c1 && op_r == OP_RDTMR)
                    acc_nxt = lnk.count;
            end
        endcase
        // an overflow beats a same-cycle flag clear
        if (lnk.ovf) tovf_nxt = 1'b1;
        // software writes take last say
        if (regWr) begin
            unique case (regAddr)
                REG_CTRL: begin
                    run_nxt  = regWdata[CTRL_RUN];
                    bank_nxt = regWdata[CTRL_BANK];
                    ext_nxt  = regWdata[CTRL_EXT];
                    tie_nxt  = regWdata[CTRL_TIE];
                end
                REG_ACC:   acc_nxt     = regWdata[7:0];
                REG_FLAGS: flagsHi_nxt = regWdata[7:4];
                REG_IEN:   ien_nxt     = regWdata[EV_W-1:0];
                default: ;
            endcase
        end
        // set wins over clear
        stat_nxt = (stat_r & ~clr) | ev;
    end

    // read path: data valid the cycle after the strobe only
    always_comb begin
        rdata_nxt = '0;
        if (regRd) begin
            unique case (regAddr)
                REG_CTRL:  rdata_nxt = DW'({lnk.mode, tie_r, ext_r,
                                            bank_r, run_r});
                REG_ACC:   rdata_nxt = DW'(acc_r);
                REG_FLAGS: rdata_nxt = DW'({flagsHi_r, 3'h0, tovf_r});
                REG_PC:    rdata_nxt = DW'({lnk.index, 4'h0, pc_r});
                REG_TCNT:  rdata_nxt = DW'(lnk.count);
                REG_STAT:  rdata_nxt = DW'(stat_r);
                REG_IEN:   rdata_nxt = DW'(ien_r);
                default:   rdata_nxt = '0;            // unmapped
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r   <= PH_S1;
            cyc2_r    <= 1'b0;
            op_r      <= OP_NOP;
            imm_r     <= '0;
            pc_r      <= '0;
            acc_r     <= '0;
            flagsHi_r <= '0;
            tovf_r    <= 1'b0;
            tie_r     <= 1'b0;
            run_r     <= 1'b0;
            bank_r    <= 1'b0;
            ext_r     <= 1'b0;
            stat_r    <= '0;
            ien_r     <= '0;
            pAddr_r   <= '0;
            pVal_r    <= 1'b0;
            xNib_r    <= '0;
            xCmd_r    <= 1'b0;
            xDat_r    <= 1'b0;
            rdata_r   <= '0;
        end else begin
            phase_r   <= phase_nxt;
            cyc2_r    <= cyc2_nxt;
            op_r      <= op_nxt;
            imm_r     <= imm_nxt;
            pc_r      <= pc_nxt;
            acc_r     <= acc_nxt;
            flagsHi_r <= flagsHi_nxt;
            tovf_r    <= tovf_nxt;
            tie_r     <= tie_nxt;
            run_r     <= run_nxt;
            bank_r    <= bank_nxt;
            ext_r     <= ext_nxt;
            stat_r    <= stat_nxt;
            ien_r     <= ien_nxt;
            pAddr_r   <= pAddr_nxt;
            pVal_r    <= pVal_nxt;
            xNib_r    <= xNib_nxt;
            xCmd_r    <= xCmd_nxt;
            xDat_r    <= xDat_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign regRdata      = rdata_r;
    assign irq           = |(stat_r & ien_r);
    assign progAddr      = pAddr_r;
    assign progAddrValid = pVal_r;
    assign expNibble     = xNib_r;
    assign expCmdStb     = xCmd_r;
    assign expDataStb    = xDat_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_callLoad;
        (exec2 && isCall) |=> (pc_r == $past(callTgt));
    endproperty
    a_callLoad: assert property (p_callLoad)
        else $error("call target not loaded");

    property p_callBank;
        (exec2 && isCall) |=> (pc_r[PC_W-1] == $past(bank_r));
    endproperty
    a_callBank: assert property (p_callBank)
        else $error("call bit 11 not from bank");

    property p_pushIdx;
        lnk.push |=> (lnk.index == $past(lnk.index) + SIDX_W'(1));
    endproperty
    a_pushIdx: assert property (p_pushIdx)
        else $error("stack index not advanced");

    property p_exitKeep;
        (exec2 && isExit && !regWr) |=> $stable(flagsHi_r);
    endproperty
    a_exitKeep: assert property (p_exitKeep)
        else $error("plain exit changed flags");

    property p_exitFlags;
        (exec2 && isExitF && !regWr) |=>
            (flagsHi_r == $past(lnk.topData[STK_W-1:PC_W]));
    endproperty
    a_exitFlags: assert property (p_exitFlags)
        else $error("flags not restored");

    property p_readTmr;
        (c1 && phase_r == PH_S5 && op_r == OP_RDTMR && !regWr) |=>
            (acc_r == $past(lnk.count));
    endproperty
    a_readTmr: assert property (p_readTmr)
        else $error("timer read mismatch");

    property p_halt;
        (c1 && phase_r == PH_S5 && op_r == OP_HALTCNT) |=>
            (lnk.mode == TM_STOP);
    endproperty
    a_halt: assert property (p_halt)
        else $error("counting not halted");

    property p_evStart;
        (c1 && phase_r == PH_S5 && op_r == OP_EVCOUNT) |=>
            (lnk.mode == TM_EVENT);
    endproperty
    a_evStart: assert property (p_evStart)
        else $error("event counting not started");

    property p_expSeq;
        (c1 && phase_r == PH_S2 && isMov) |=>
            (expCmdStb && phase_r == PH_S3) ##2
            (expDataStb && phase_r == PH_S5);
    endproperty
    a_expSeq: assert property (p_expSeq)
        else $error("expander strobes out of place");

    property p_addrVal;
        progAddrValid |-> (phase_r == PH_S2 && ext_r);
    endproperty
    a_addrVal: assert property (p_addrVal)
        else $error("address valid outside S2");

    property p_tirq;
        (lnk.ovf && tie_r) |=> stat_r[EV_TIRQ];
    endproperty
    a_tirq: assert property (p_tirq)
        else $error("timer request lost");

    c_call:  cover property (exec2 && isCall);
    c_exitF: cover property (exec2 && isExitF);
    c_movX:  cover property (expDataStb);
    c_irq:   cover property (irq && stat_r[EV_TIRQ]);
endmodule : mste_core

// File: sim/mste_prog_mem.sv
// external program memory, answers at once from the address
module mste_prog_mem (
    input  wire logic [11:0] progAddr,
    output logic      [7:0]  progData
);
    timeunit 1ns;
    timeprecision 1ps;
    // fixed program; empty places read as no-op
    always_comb begin
        case (progAddr)
            12'h000: progData = 8'h3D; // expander write, port 1
            12'h001: progData = 8'h62; // load timer from acc
            12'h002: progData = 8'h14; // call, bank bits 0
            12'h003: progData = 8'h20; // call target low byte
            12'h004: progData = 8'h42; // read timer into acc
            12'h005: progData = 8'h65; // halt counting
            12'h006: progData = 8'h45; // begin event counting
            12'h007: progData = 8'h04; // jump to self parks core
            12'h008: progData = 8'h07;
            12'h020: progData = 8'h93; // exit restoring flags
            default: progData = 8'h00;
        endcase
    end
endmodule : mste_prog_mem

// File: sim/mste_core_tb.sv
module mste_core_tb;
    import mste_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_n = 0, regWr = 0, regRd = 0;
    logic [7:0]  regAddr = 8'h00, progData, accVal;
    logic [31:0] regWdata = 32'h0, regRdata, rd;
    logic [11:0] progAddr;
    logic [3:0]  expNibble;
    logic        irq, progAddrValid, expCmdStb, expDataStb;
    logic        evtPin = 1'b1; // event pin idles high, falls count
    int          bad_count = 0, checks = 0, n, k;
    always #2.5 clk_sys = ~clk_sys; // 200 MHz
    mste_core mste_core_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq),
        .progData(progData), .progAddr(progAddr),
        .progAddrValid(progAddrValid), .evtPin(evtPin),
        .expNibble(expNibble), .expCmdStb(expCmdStb),
        .expDataStb(expDataStb));
    mste_prog_mem mste_prog_mem_inst (.progAddr(progAddr),
        .progData(progData));
    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        regRd <= 1'b1; regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask : rdr
    task automatic conclude();
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // bounded wait on a design strobe
    task automatic waitFor(ref logic s, input int lim);
        n = 0;
        do begin @(posedge clk_sys); #1 n++; end
        while (s !== 1'b1 && n < lim);
        chk({31'h0, s}, 32'h1);
    endtask : waitFor
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'h75C75077));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        accVal = 8'($urandom());
        wr(REG_ACC, {24'h0, accVal});
        wr(REG_IEN, 32'h2); // unmask call event only
        wr(REG_CTRL, 32'h5); // run, external memory
        waitFor(expCmdStb, 100);
        chk({28'h0, expNibble}, 32'h5);
        waitFor(expDataStb, 3);
        chk({28'h0, expNibble}, {28'h0, accVal[3:0]});
        repeat (200) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1); // enabled call event pending
        // random count of falling edges, each wide enough to sync
        k = 1 + int'($urandom_range(7));
        repeat (k) begin
            evtPin <= 1'b0;
            repeat (4) @(posedge clk_sys);
            evtPin <= 1'b1;
            repeat (4) @(posedge clk_sys);
        end
        rdr(REG_CTRL);
        chk({30'h0, rd[5:4]}, 32'h2);
        rdr(REG_TCNT);
        chk(rd, {24'h0, 8'(accVal + k)});
        rdr(REG_ACC);
        chk(rd, {24'h0, accVal});
        rdr(REG_PC);
        chk({29'h0, rd[18:16]}, 32'h0);
        chk({31'h0, rd[11:0] >= 12'h007 && rd[11:0] <= 12'h009},
            32'h1);
        rdr(REG_STAT);
        chk(rd, 32'h6); // call and exit seen, no timer event
        wr(REG_IEN, 32'h0); // masked: level must drop
        #1 chk({31'h0, irq}, 32'h0);
        wr(REG_ICLR, 32'h7);
        wr(REG_IEN, 32'h7);
        #1 chk({31'h0, irq}, 32'h0);
        rdr(REG_STAT);
        chk(rd, 32'h0);
        rdr(8'h40); // unmapped place reads zero
        chk(rd, 32'h0);
        conclude();
    end
endmodule : mste_core_tb
